// ---- rtl/dsw_params.svh ----
`ifndef DSW_PARAMS_SVH
`define DSW_PARAMS_SVH

// ===========================================================
// Register byte offsets
`define DSW_OFS_STATE    8'h00
`define DSW_OFS_SOURCE   8'h04
`define DSW_OFS_FREQ     8'h08
`define DSW_OFS_PROFILE  8'h0C
`define DSW_OFS_HSP      8'h10
`define DSW_OFS_LSP      8'h14

// ===========================================================
// Span cap and reset values, frequencies in 0.1 Hz
`define DSW_SPAN_MAX     16'h1766
`define DSW_HSP_RST      16'h01F4
`define DSW_LSP_RST      16'h0000
`define DSW_PROF_RST     2'h0

// ===========================================================
// Profile codes
`define DSW_PROF_COMB    2'h0
`define DSW_PROF_SEP     2'h1
`define DSW_PROF_IO      2'h2

// ===========================================================
// Reference source codes
`define DSW_SRC_TERM     3'h0
`define DSW_SRC_DISP     3'h1
`define DSW_SRC_MODBUS   3'h2
`define DSW_SRC_CARD_CAN 3'h3
`define DSW_SRC_CARD_FB  3'h4
`define DSW_SRC_LAN      3'h5
`define DSW_SRC_TOOL     3'h6

// ===========================================================
// Synchronised input vector layout
`define DSW_IN_W         34
`define DSW_IN_RDY_SO    0
`define DSW_IN_SW_ON     1
`define DSW_IN_OP_EN     2
`define DSW_IN_FAULT     3
`define DSW_IN_PWR       4
`define DSW_IN_PWR_ONLY  5
`define DSW_IN_QSTOP     6
`define DSW_IN_SO_DIS    7
`define DSW_IN_WARN      8
`define DSW_IN_REMOTE    9
`define DSW_IN_REACHED   10
`define DSW_IN_STOPKEY   11
`define DSW_IN_REVERSE   12
`define DSW_IN_SRC_LO    13
`define DSW_IN_SRC_HI    15
`define DSW_IN_CAN_PRES  16
`define DSW_IN_FB_PRES   17
`define DSW_IN_REF_LO    18
`define DSW_IN_REF_HI    33
`endif

// ---- rtl/dsw_pkg.sv ----
package dsw_pkg;
    typedef logic [2:0]  dsw_src_t;
    typedef logic [1:0]  dsw_prof_t;
    typedef logic [15:0] dsw_word_t;

    typedef struct packed {
        dsw_prof_t   profile;
        dsw_word_t   hsp;
        dsw_word_t   low_speed_limit;
        dsw_word_t   state_word;
        dsw_src_t    source;
        dsw_word_t   freq;
        logic [31:0] rdata;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic        ready;
    } dsw_st_t;
endpackage : dsw_pkg

// ---- rtl/dsw_sync_if.sv ----
`timescale 1ns/1ps
interface dsw_sync_if #(parameter int W = 1);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : dsw_sync_if

// ---- rtl/dsw_sync.sv ----
`timescale 1ns/1ps
// ===========================================================
// Three-stage input filter
module dsw_sync #(
    parameter int W = 1
) (
    input  wire logic SYS_CLK,
    input  wire logic RESETN,
    dsw_sync_if.sync  sif
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } dsw_sync_st_t;

    dsw_sync_st_t st_ff;
    dsw_sync_st_t nxt_st;

    // First stage feeds only the second; a bit moves once 2 and 3 agree
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = sif.raw;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int i = 0; i < W; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.q[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sif.clean = st_ff.q;
endmodule : dsw_sync

// ---- rtl/dsw_monitor.sv ----
// The address map and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
`include "dsw_params.svh"
module dsw_monitor (
    input  wire logic          SYS_CLK,
    input  wire logic          RESETN,
    input  wire logic          HSEL,
    input  wire logic [31:0]   HADDR,
    input  wire logic [1:0]    HTRANS,
    input  wire logic          HWRITE,
    input  wire logic [2:0]    HSIZE,
    input  wire logic [31:0]   HWDATA,
    input  wire logic          HREADY,
    output logic      [31:0]   HRDATA,
    output logic               HREADYOUT,
    output logic               HRESP,
    input  wire logic          READY_SWITCH_ON,
    input  wire logic          SWITCHED_ON,
    input  wire logic          OP_ENABLED,
    input  wire logic          FAULT_ACTIVE,
    input  wire logic          POWER_PRESENT,
    input  wire logic          POWER_STAGE_ONLY,
    input  wire logic          QUICK_STOP,
    input  wire logic          SWITCH_ON_DISABLED,
    input  wire logic          WARNING,
    input  wire logic          REMOTE_NETWORK,
    input  wire logic          REF_REACHED,
    input  wire logic          STOP_KEY,
    input  wire logic          REVERSE_DIR,
    input  wire dsw_pkg::dsw_src_t  REF_SOURCE_SEL,
    input  wire logic          CAN_CARD_PRESENT,
    input  wire logic          FIELDBUS_CARD_PRESENT,
    input  wire dsw_pkg::dsw_word_t REF_RAW,
    output dsw_pkg::dsw_word_t STATE_WORD,
    output dsw_pkg::dsw_src_t  REF_SOURCE,
    output dsw_pkg::dsw_word_t PRE_RAMP_FREQ
);
    import dsw_pkg::*;

    // ===========================================================
    // Input synchronisation
    dsw_sync_if #(.W(`DSW_IN_W)) sif ();

    assign sif.raw = {REF_RAW,
                      FIELDBUS_CARD_PRESENT,
                      CAN_CARD_PRESENT,
                      REF_SOURCE_SEL,
                      REVERSE_DIR,
                      STOP_KEY,
                      REF_REACHED,
                      REMOTE_NETWORK,
                      WARNING,
                      SWITCH_ON_DISABLED,
                      QUICK_STOP,
                      POWER_STAGE_ONLY,
                      POWER_PRESENT,
                      FAULT_ACTIVE,
                      OP_ENABLED,
                      SWITCHED_ON,
                      READY_SWITCH_ON};

    // A multi-bit reference may be seen half-updated for a cycle;
    // the drive is expected to hold it steady for several cycles.
    dsw_sync #(.W(`DSW_IN_W)) u_sync (
        .SYS_CLK (SYS_CLK),
        .RESETN  (RESETN),
        .sif     (sif)
    );

    dsw_st_t st_ff;
    dsw_st_t nxt_st;

    logic [`DSW_IN_W-1:0] in_c;
    assign in_c = sif.clean;

    // ===========================================================
    // Reference source
    dsw_src_t src_in;
    dsw_src_t src_eff;

    always_comb begin
        src_in  = in_c[`DSW_IN_SRC_HI:`DSW_IN_SRC_LO];
        src_eff = `DSW_SRC_TERM;
        if (src_in == `DSW_SRC_CARD_CAN) begin
            if (in_c[`DSW_IN_CAN_PRES]) begin
                src_eff = `DSW_SRC_CARD_CAN;
            end
        end else if (src_in == `DSW_SRC_CARD_FB) begin
            if (in_c[`DSW_IN_FB_PRES]) begin
                src_eff = `DSW_SRC_CARD_FB;
            end
        end else if (src_in <= `DSW_SRC_TOOL) begin
            src_eff = src_in;
        end
    end

    // ===========================================================
    // Pre-ramp frequency clamp
    logic signed [15:0] ref_s;
    logic signed [15:0] lim_s;
    logic signed [15:0] freq_c;
    logic        [15:0] ref_mag;
    logic        [15:0] lim_u;
    logic               out_lim;

    always_comb begin
        ref_s = $signed(in_c[`DSW_IN_REF_HI:`DSW_IN_REF_LO]);
        // Limit itself is capped so a bad setting cannot widen the span
        if (st_ff.hsp > `DSW_SPAN_MAX) begin
            lim_u = `DSW_SPAN_MAX;
        end else begin
            lim_u = st_ff.hsp;
        end
        lim_s = $signed(lim_u);
        if (ref_s > lim_s) begin
            freq_c = lim_s;
        end else if (ref_s < -lim_s) begin
            freq_c = -lim_s;
        end else begin
            freq_c = ref_s;
        end
        if (ref_s[15]) begin
            ref_mag = 16'(-ref_s);
        end else begin
            ref_mag = 16'(ref_s);
        end
        // Unclamped magnitude against both speed limits
        out_lim = (ref_mag > st_ff.hsp) || (ref_mag < st_ff.low_speed_limit);
    end

    // ===========================================================
    // State word composition
    logic io_prof;
    dsw_word_t sw;

    always_comb begin
        io_prof = (st_ff.profile != `DSW_PROF_COMB) &&
                  (st_ff.profile != `DSW_PROF_SEP);
        sw      = 16'h0000;
        // Bits 0..6 together carry the drive state position
        sw[0]   = in_c[`DSW_IN_RDY_SO];
        sw[1]   = in_c[`DSW_IN_SW_ON];
        sw[2]   = in_c[`DSW_IN_OP_EN];
        sw[3]   = in_c[`DSW_IN_FAULT];
        sw[4]   = in_c[`DSW_IN_PWR] | in_c[`DSW_IN_PWR_ONLY];
        sw[5]   = io_prof | ~in_c[`DSW_IN_QSTOP];
        sw[6]   = in_c[`DSW_IN_SO_DIS];
        sw[7]   = in_c[`DSW_IN_WARN];
        sw[9]   = in_c[`DSW_IN_REMOTE];
        sw[10]  = in_c[`DSW_IN_REACHED];
        sw[11]  = out_lim;
        sw[14]  = in_c[`DSW_IN_STOPKEY];
        sw[15]  = in_c[`DSW_IN_REVERSE];
        // Reserved bits 8, 12 and 13 stay zero in every profile, so
        // all three profiles read the same number apart from bit 5
    end

    // ===========================================================
    // AHB-Lite slave, zero wait states
    logic       addr_ok;
    logic [7:0] a_lo;
    logic [31:0] rd_c;

    always_comb begin
        addr_ok = HSEL && HTRANS[1] && HREADY;
        a_lo    = HADDR[7:0];
        // Upper address bits must be zero for a hit; unmapped words read as zero
        if (HADDR[31:8] != 24'h000000) begin
            rd_c = 32'h00000000;
        end else if (a_lo == `DSW_OFS_STATE) begin
            rd_c = {16'h0000, st_ff.state_word};
        end else if (a_lo == `DSW_OFS_SOURCE) begin
            rd_c = {29'h00000000, st_ff.source};
        end else if (a_lo == `DSW_OFS_FREQ) begin
            rd_c = {{16{st_ff.freq[15]}}, st_ff.freq};
        end else if (a_lo == `DSW_OFS_PROFILE) begin
            rd_c = {30'h00000000, st_ff.profile};
        end else if (a_lo == `DSW_OFS_HSP) begin
            rd_c = {16'h0000, st_ff.hsp};
        end else if (a_lo == `DSW_OFS_LSP) begin
            rd_c = {16'h0000, st_ff.low_speed_limit};
        end else begin
            rd_c = 32'h00000000;
        end
    end

    always_comb begin
        nxt_st            = st_ff;
        nxt_st.state_word = sw;
        nxt_st.source     = src_eff;
        nxt_st.freq       = 16'(freq_c);
        nxt_st.ready      = 1'b1;
        nxt_st.wr_pend    = 1'b0;
        if (addr_ok && !HWRITE) begin
            nxt_st.rdata = rd_c;
        end
        if (addr_ok && HWRITE) begin
            nxt_st.wr_pend = (HADDR[31:8] == 24'h000000);
            nxt_st.wr_addr = a_lo;
        end
        // Status registers ignore writes; only settings take data
        if (st_ff.wr_pend) begin
            if (st_ff.wr_addr == `DSW_OFS_PROFILE) begin
                nxt_st.profile = HWDATA[1:0];
            end else if (st_ff.wr_addr == `DSW_OFS_HSP) begin
                nxt_st.hsp = HWDATA[15:0];
            end else if (st_ff.wr_addr == `DSW_OFS_LSP) begin
                nxt_st.low_speed_limit = HWDATA[15:0];
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_ff            <= '0;
            st_ff.profile    <= `DSW_PROF_RST;
            st_ff.hsp        <= `DSW_HSP_RST;
            st_ff.low_speed_limit        <= `DSW_LSP_RST;
            st_ff.state_word <= 16'h0020;
            st_ff.source     <= `DSW_SRC_TERM;
            st_ff.ready      <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign HRDATA        = st_ff.rdata;
    assign HREADYOUT     = st_ff.ready;
    assign HRESP         = 1'b0;
    assign STATE_WORD    = st_ff.state_word;
    assign REF_SOURCE    = st_ff.source;
    assign PRE_RAMP_FREQ = st_ff.freq;
endmodule : dsw_monitor

// ---- sim/dsw_monitor_props.sv ----
`timescale 1ns/1ps
// ===========================================================
// Port-level checks of the status monitor
module dsw_monitor_props (
    input wire logic               SYS_CLK,
    input wire logic               RESETN,
    input wire logic               HSEL,
    input wire logic [31:0]        HADDR,
    input wire logic [1:0]         HTRANS,
    input wire logic               HWRITE,
    input wire logic               HREADY,
    input wire logic [31:0]        HRDATA,
    input wire logic               HREADYOUT,
    input wire logic               HRESP,
    input wire logic               FAULT_ACTIVE,
    input wire logic               WARNING,
    input wire logic               POWER_STAGE_ONLY,
    input wire logic               CAN_CARD_PRESENT,
    input wire logic               FIELDBUS_CARD_PRESENT,
    input wire dsw_pkg::dsw_word_t STATE_WORD,
    input wire dsw_pkg::dsw_src_t  REF_SOURCE,
    input wire dsw_pkg::dsw_word_t PRE_RAMP_FREQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    logic rd_taken;
    // Eight samples cover the five-edge input latency plus reset release
    assign rd_taken = HSEL && HTRANS[1] && HREADY && !HWRITE;
    a_no_wait: assert property (HREADYOUT) else $error("wait state");
    a_resp_okay: assert property (!HRESP) else $error("error response");
    a_rsvd_zero: assert property ((STATE_WORD & 16'h3100) == 16'h0000)
        else $error("reserved bit set");
    a_fault_bit: assert property (FAULT_ACTIVE [*8] |-> STATE_WORD[3])
        else $error("fault bit missing");
    a_warn_bit: assert property (!WARNING [*8] |-> !STATE_WORD[7])
        else $error("warning bit stuck");
    a_pwr_only: assert property (POWER_STAGE_ONLY [*8] |-> STATE_WORD[4])
        else $error("power bit missing");
    a_card_gate: assert property ((!CAN_CARD_PRESENT [*8] |->
        REF_SOURCE != 3'h3) and (!FIELDBUS_CARD_PRESENT [*8] |->
        REF_SOURCE != 3'h4)) else $error("absent card as source");
    a_freq_clamp: assert property ($signed(PRE_RAMP_FREQ) <= $signed(16'h1766)
        && $signed(PRE_RAMP_FREQ) >= $signed(16'hE89A))
        else $error("frequency beyond span");
    a_rd_state: assert property (rd_taken && HADDR == 32'h0000_0000 |=>
        HRDATA == {16'h0000, $past(STATE_WORD)})
        else $error("state read differs");
    c_fault: cover property (STATE_WORD[3]);
    c_tool: cover property (REF_SOURCE == 3'h6);
    c_clamp: cover property (PRE_RAMP_FREQ == 16'h1766);
endmodule : dsw_monitor_props
bind dsw_monitor dsw_monitor_props u_dsw_monitor_props (.SYS_CLK, .RESETN,
    .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP,
    .FAULT_ACTIVE, .WARNING, .POWER_STAGE_ONLY, .CAN_CARD_PRESENT,
    .FIELDBUS_CARD_PRESENT, .STATE_WORD, .REF_SOURCE, .PRE_RAMP_FREQ);

// ---- sim/dsw_ahb_master.sv ----
`timescale 1ns/1ps
// ===========================================================
// Host reading drive status over the register bus
module dsw_ahb_master (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    int n_to = 0;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // Bounded waits; a hang is counted and the caller reports it
    task automatic xfer(input logic w, input logic [31:0] a, d,
                        output logic [31:0] r);
        int k;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        k = 0;
        do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
        if (k >= 50) n_to++;
        htrans <= 2'h0;
        hwdata <= w ? d : ~hwdata;
        k = 0;
        do begin @(posedge clk); k++; end while (hready !== 1'b1 && k < 50);
        r = hrdata;
        if (k >= 50) n_to++;
    endtask : xfer
endmodule : dsw_ahb_master

// ---- sim/drive_status_word_monitor_bench.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module drive_status_word_monitor_bench;
    import dsw_pkg::*;
    logic        SYS_CLK = 1'b0;
    logic        RESETN = 1'b0;
    logic [12:0] pins = '0;
    dsw_src_t    src_sel = '0;
    logic [1:0]  cards = '0;
    dsw_word_t   ref_raw = '0;
    logic        hsel, hwrite, hready, hresp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata;
    dsw_word_t   sw, freq;
    dsw_src_t    src;
    int          n_fail = 0;
    int          n_tests = 0;
    // Expected word with one status pin high, combined profile
    localparam logic [15:0] EXP [13] = '{16'h0021, 16'h0022, 16'h0024,
        16'h0028, 16'h0030, 16'h0030, 16'h0000, 16'h0060, 16'h00A0,
        16'h0220, 16'h0420, 16'h4020, 16'h8020};
    always #25 SYS_CLK = ~SYS_CLK;
    dsw_ahb_master u_dsw_ahb_master (.clk(SYS_CLK), .hready(hready),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    dsw_monitor u_dsw_monitor (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .READY_SWITCH_ON(pins[0]),
        .SWITCHED_ON(pins[1]), .OP_ENABLED(pins[2]), .FAULT_ACTIVE(pins[3]),
        .POWER_PRESENT(pins[4]), .POWER_STAGE_ONLY(pins[5]),
        .QUICK_STOP(pins[6]), .SWITCH_ON_DISABLED(pins[7]),
        .WARNING(pins[8]), .REMOTE_NETWORK(pins[9]), .REF_REACHED(pins[10]),
        .STOP_KEY(pins[11]), .REVERSE_DIR(pins[12]), .REF_SOURCE_SEL(src_sel),
        .CAN_CARD_PRESENT(cards[0]), .FIELDBUS_CARD_PRESENT(cards[1]),
        .REF_RAW(ref_raw), .STATE_WORD(sw), .REF_SOURCE(src),
        .PRE_RAMP_FREQ(freq));
    // ===========================================================
    // Bus helpers
    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        u_dsw_ahb_master.xfer(1'b0, a, 32'h0, r);
    endtask : rd
    task automatic wr(input logic [31:0] a, d);
        logic [31:0] r;
        u_dsw_ahb_master.xfer(1'b1, a, d, r);
    endtask : wr
    // Pins pass a filter of four edges, then the state register
    task automatic settle;
        repeat (8) @(posedge SYS_CLK);
    endtask : settle
    // ===========================================================
    // Scenarios
    task automatic t_regs;
        logic [31:0] r;
        rd(32'h10, r); `CHK("hsp", 32'h0000_01F4, r)
        rd(32'h14, r); `CHK("lsp", 32'h0, r)
        rd(32'h0C, r); `CHK("profile", 32'h0, r)
        rd(32'h04, r); `CHK("src rst", 32'h0, r)
        rd(32'h40, r); `CHK("unmapped", 32'h0, r)
        wr(32'h00, 32'hFFFF_FFFF);
        rd(32'h00, r); `CHK("ro state", 32'h0000_0020, r)
        `CHK("resp", 1'b0, hresp)
        $display("test regs done");
    endtask : t_regs
    task automatic t_bits;
        logic [31:0] r;
        for (int i = 0; i < 13; i++) begin
            @(posedge SYS_CLK);
            pins <= 13'h1 << i;
            settle();
            `CHK("state", EXP[i], sw)
            rd(32'h00, r); `CHK("rd state", {16'h0, EXP[i]}, r)
        end
        $display("test bits done");
    endtask : t_bits
    task automatic t_prof;
        logic [31:0] r;
        wr(32'h0C, 32'h2);
        rd(32'h0C, r); `CHK("io prof", 32'h2, r)
        @(posedge SYS_CLK);
        pins <= 13'h0041;
        settle();
        `CHK("io qstop", 16'h0021, sw)
        wr(32'h0C, 32'h0);
        settle();
        `CHK("cia qstop", 16'h0001, sw)
        pins <= 13'h0;
        $display("test profile done");
    endtask : t_prof
    task automatic t_src;
        logic [31:0] r;
        cards <= 2'b11;
        for (int c = 0; c < 7; c++) begin
            @(posedge SYS_CLK);
            src_sel <= c[2:0];
            settle();
            `CHK("source", c[2:0], src)
        end
        rd(32'h04, r); `CHK("rd src", 32'h6, r)
        for (int c = 3; c < 5; c++) begin
            @(posedge SYS_CLK);
            cards <= 2'b00;
            src_sel <= c[2:0];
            settle();
            `CHK("no card", 3'h0, src)
        end
        @(posedge SYS_CLK);
        src_sel <= 3'h7;
        settle();
        `CHK("bad code", 3'h0, src)
        $display("test source done");
    endtask : t_src
    task automatic t_freq;
        logic [31:0] r;
        ref_raw <= 16'h03E8;
        settle();
        `CHK("clamp hi", 16'h01F4, freq)
        `CHK("limit bit", 1'b1, sw[11])
        ref_raw <= 16'hFC18;
        settle();
        rd(32'h08, r); `CHK("clamp lo", 32'hFFFF_FE0C, r)
        wr(32'h10, 32'h2000);
        ref_raw <= 16'h7000;
        settle();
        `CHK("span hi", 16'h1766, freq)
        ref_raw <= 16'h8001;
        settle();
        `CHK("span lo", 16'hE89A, freq)
        ref_raw <= 16'h0064;
        settle();
        `CHK("pass", 16'h0064, freq)
        `CHK("in range", 1'b0, sw[11])
        wr(32'h14, 32'h00C8);
        settle();
        `CHK("below lsp", 1'b1, sw[11])
        $display("test freq done");
    endtask : t_freq
    task automatic summarize;
        n_fail += u_dsw_ahb_master.n_to;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (12) @(posedge SYS_CLK);
        RESETN <= 1'b1;
        t_regs();
        t_bits();
        t_prof();
        t_src();
        t_freq();
        summarize();
    end
endmodule : drive_status_word_monitor_bench
